// [hdl/dma_timer.sv]
// Watchdog counter that flags when its run input has stayed high for LIMIT cycles.
`default_nettype none
module dma_timer #(
  parameter logic [11:0] LIMIT = 12'h001
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,
  output logic      expired
);
  logic [11:0] cnt_q;
  logic        exp_q;

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 12'h000;
      exp_q <= 1'b0;
    end else if (cnt_q == LIMIT - 12'h001) begin
      exp_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  assign expired = exp_q;

  property p_timer_exact;
    @(posedge mclk) disable iff (rst) $rose(exp_q) |-> cnt_q == LIMIT - 12'h001;
  endproperty
  a_timer_exact : assert property (p_timer_exact) else $error("timer expired at wrong count");
endmodule : dma_timer
`default_nettype wire

// [hdl/translation_ram.sv]
// Flip-flop translation RAM of 256 words with parity generated on write.
`default_nettype none
module translation_ram (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [11:0] wdata,
  input  wire logic        evenPar,
  input  wire logic [7:0]  raddr,
  output logic      [12:0] rdata
);
  logic [12:0] mem [256];
  logic        parBit;
  logic [12:0] word;

  // Odd parity sets the bit when the twelve data bits hold an even count of ones.
  assign parBit = evenPar ? (^wdata) : ~(^wdata);
  assign word   = {parBit, wdata};

  for (genvar i = 0; i < 256; i++) begin : g_word
    always_ff @(posedge mclk) begin
      if (we && waddr == 8'(i)) begin
        mem[i] <= word;
      end
    end
  end

  assign rdata = mem[raddr];

  property p_par_stored;
    @(posedge mclk) disable iff (rst) we |=> (^mem[$past(waddr)]) != $past(evenPar);
  endproperty
  a_par_stored : assert property (p_par_stored) else $error("stored word has wrong parity");
endmodule : translation_ram
`default_nettype wire

// [hdl/translation_ram_dma_loader.sv]
// Translation RAM DMA loader: registers, mode decode, bus requests and byte sequencing.
`default_nettype none
module translation_ram_dma_loader (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        busInit,
  input  wire logic        acLo,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dmaReq,
  input  wire logic        dmaGrant,
  output logic             msyn,
  output logic      [17:0] dmaAddr,
  input  wire logic        ssyn,
  input  wire logic [15:0] dmaRdata,
  output logic             intReq,
  input  wire logic        printerDemand,
  output logic             printerStrobe,
  output logic      [7:0]  printerData
);
  tram_loader_pkg::state_t state_q, state_d;

  logic        go_q, testMode_q, fmtLoad_q, intEn_q, done_q;
  logic [1:0]  addrX_q;
  logic        memErr_q, demErr_q;
  logic [2:0]  testType_q;
  logic [15:0] busAddr_q;
  logic [11:0] byteCnt_q;
  logic [7:0]  cksum_q, charBuf_q, ramAddr_q;
  logic        strobe_q, demandD_q;
  logic        dmaReq_q, msyn_q, intReq_q, lptStrobe_q;
  logic [17:0] dmaAddr_q;
  logic [7:0]  lptData_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic [15:0] csraVal, csrbVal, rdMux;
  logic [12:0] ramRdata;

  // Register bus decode.
  wire logic apbAcc = psel & penable;
  wire logic apbWr  = apbAcc & pwrite & pready_q;
  wire logic selA   = paddr == tram_loader_pkg::OFF_CONTROL_STATUS_FIRST;
  wire logic selB   = paddr == tram_loader_pkg::OFF_CONTROL_STATUS_SECOND;
  wire logic selBa  = paddr == tram_loader_pkg::OFF_BADDR;
  wire logic selBc  = paddr == tram_loader_pkg::OFF_BCNT;
  wire logic selCk  = paddr == tram_loader_pkg::OFF_CKSUM;
  wire logic selRa  = paddr == tram_loader_pkg::OFF_RAMADR;
  wire logic selRd  = paddr == tram_loader_pkg::OFF_RAMDAT;
  wire logic mapped = selA | selB | selBa | selBc | selCk | selRa | selRd;
  wire logic csraWr = apbWr & selA;
  wire logic goSet  = csraWr & pwdata[tram_loader_pkg::A_GO] & ~go_q;
  wire logic errRst = csraWr & pwdata[tram_loader_pkg::A_ERRRST];
  wire logic lInit  = csraWr & pwdata[tram_loader_pkg::A_LINIT];
  wire logic clr    = rst | busInit | lInit;

  // Mode decode.
  wire logic [1:0] mode = {fmtLoad_q, testMode_q};
  wire logic isRamLoad  = mode == tram_loader_pkg::MODE_RAMLOAD;
  wire logic isSim      = isRamLoad | (mode == tram_loader_pkg::MODE_TEST);
  wire logic errAny     = memErr_q | demErr_q;
  wire logic evenPar    = testType_q == tram_loader_pkg::TT_RAMPAR;

  // Transfer events.
  wire logic inReq    = state_q == tram_loader_pkg::ST_REQ;
  wire logic inXfer   = state_q == tram_loader_pkg::ST_XFER;
  wire logic inStrobe = state_q == tram_loader_pkg::ST_STROBE;
  wire logic granted  = inReq & dmaReq_q & dmaGrant;
  wire logic capture  = inXfer & msyn_q & ssyn;
  wire logic memExp;
  wire logic demExp;
  wire logic toErr    = inXfer & memExp & ~capture;
  // The internal simulation drops the strobe at once; a real printer drops it by raising demand.
  wire logic strobeClr = isSim | printerDemand;
  wire logic demErr    = inStrobe & ~strobeClr & demExp;
  wire logic endStrobe = inStrobe & strobeClr;
  wire logic finish    = endStrobe & (byteCnt_q == tram_loader_pkg::BCNT_LAST);
  wire logic demandRise = printerDemand & ~demandD_q;
  wire logic [7:0] byteSel = busAddr_q[0] ? dmaRdata[15:8] : dmaRdata[7:0];

  dma_timer #(.LIMIT(tram_loader_pkg::MEM_TO_CYC)) u_memTimer (
    .mclk    (mclk),
    .rst     (clr),
    .run     (inXfer & msyn_q),
    .expired (memExp)
  );

  dma_timer #(.LIMIT(tram_loader_pkg::DEMAND_TO_CYC)) u_demTimer (
    .mclk    (mclk),
    .rst     (clr),
    .run     (inStrobe),
    .expired (demExp)
  );

  translation_ram u_ram (
    .mclk    (mclk),
    .rst     (clr),
    .we      (capture & isRamLoad),
    .waddr   (ramAddr_q),
    .wdata   (dmaRdata[11:0]),
    .evenPar (evenPar),
    .raddr   (ramAddr_q),
    .rdata   (ramRdata)
  );

  // A halted controller with go still set picks up again once the error is cleared.
  always_comb begin
    state_d = state_q;
    case (state_q)
      tram_loader_pkg::ST_IDLE: begin
        if (go_q && !errAny) state_d = tram_loader_pkg::ST_REQ;
      end
      tram_loader_pkg::ST_REQ: begin
        if (errAny) state_d = tram_loader_pkg::ST_IDLE;
        else if (granted) state_d = tram_loader_pkg::ST_XFER;
      end
      tram_loader_pkg::ST_XFER: begin
        if (capture) state_d = tram_loader_pkg::ST_STROBE;
        else if (toErr) state_d = tram_loader_pkg::ST_IDLE;
      end
      tram_loader_pkg::ST_STROBE: begin
        if (demErr || finish) state_d = tram_loader_pkg::ST_IDLE;
        else if (endStrobe) state_d = tram_loader_pkg::ST_REQ;
      end
      default: state_d = tram_loader_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (clr) state_q <= tram_loader_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  // Control bits; hardware clearing of go is placed last so it wins.
  always_ff @(posedge mclk) begin
    if (clr) begin
      go_q       <= 1'b0;
      testMode_q <= 1'b0;
      fmtLoad_q  <= 1'b0;
      addrX_q    <= 2'h0;
      intEn_q    <= 1'b0;
      testType_q <= 3'h0;
    end else begin
      if (csraWr) begin
        go_q       <= pwdata[tram_loader_pkg::A_GO];
        testMode_q <= pwdata[tram_loader_pkg::A_TEST];
        fmtLoad_q  <= pwdata[tram_loader_pkg::A_FMT];
        addrX_q    <= pwdata[tram_loader_pkg::A_ADRX +: 2];
        intEn_q    <= pwdata[tram_loader_pkg::A_INTEN];
      end
      if (apbWr && selB) testType_q <= pwdata[tram_loader_pkg::B_TTYPE +: 3];
      if (finish) go_q <= 1'b0;
    end
  end

  // The demand edge detector follows the pin through a local or bus initialize.
  // Clearing it there would report a false rising edge while the printer stays on-line.
  always_ff @(posedge mclk) begin
    if (rst) demandD_q <= 1'b0;
    else demandD_q <= printerDemand;
  end

  // Status flags: a setting event beats a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (clr) begin
      done_q    <= 1'b0;
      memErr_q  <= 1'b0;
      demErr_q  <= 1'b0;
    end else begin
      if (finish || demandRise) done_q <= 1'b1;
      else if (goSet) done_q <= 1'b0;
      if (toErr) memErr_q <= 1'b1;
      else if (errRst) memErr_q <= 1'b0;
      if (demErr) demErr_q <= 1'b1;
      else if (errRst) demErr_q <= 1'b0;
    end
  end

  // Address, count, buffer and checksum datapath.
  always_ff @(posedge mclk) begin
    if (clr) begin
      busAddr_q <= 16'h0000;
      byteCnt_q <= 12'h000;
      ramAddr_q <= 8'h00;
      charBuf_q <= 8'h00;
      cksum_q   <= 8'h00;
    end else begin
      if (apbWr && selBa) busAddr_q <= pwdata[15:0];
      if (apbWr && selBc) byteCnt_q <= pwdata[11:0];
      if (apbWr && selRa && !go_q) ramAddr_q <= pwdata[7:0];
      if (goSet) ramAddr_q <= tram_loader_pkg::RAM_FIRST;
      if (capture) begin
        busAddr_q <= busAddr_q + 16'h0001;
        byteCnt_q <= byteCnt_q + 12'h001;
        charBuf_q <= byteSel;
        cksum_q   <= cksum_q + byteSel;
        if (busAddr_q[0]) ramAddr_q <= ramAddr_q + 8'h01;
      end
    end
  end

  // Bus master and printer side signals.
  always_ff @(posedge mclk) begin
    if (clr) begin
      dmaReq_q    <= 1'b0;
      msyn_q      <= 1'b0;
      dmaAddr_q   <= 18'h00000;
      intReq_q    <= 1'b0;
      strobe_q    <= 1'b0;
      lptStrobe_q <= 1'b0;
      lptData_q   <= 8'h00;
    end else begin
      dmaReq_q <= inReq & ~granted & ~errAny & ~acLo;
      if (granted) begin
        msyn_q    <= 1'b1;
        dmaAddr_q <= {addrX_q, busAddr_q};
      end else if (capture || toErr) begin
        msyn_q <= 1'b0;
      end
      intReq_q <= intEn_q & (done_q | errAny) & ~acLo;
      if (capture) strobe_q <= 1'b1;
      else if (endStrobe) strobe_q <= 1'b0;
      lptStrobe_q <= capture & ~isSim;
      if (capture && !isSim) lptData_q <= byteSel;
    end
  end

  // Read mux and register bus answer; the answer comes one cycle into the access phase.
  always_comb begin
    csraVal = 16'h0000;
    csraVal[tram_loader_pkg::A_GO]      = go_q;
    csraVal[tram_loader_pkg::A_TEST]    = testMode_q;
    csraVal[tram_loader_pkg::A_FMT]     = fmtLoad_q;
    csraVal[tram_loader_pkg::A_ADRX +: 2] = addrX_q;
    csraVal[tram_loader_pkg::A_INTEN]   = intEn_q;
    csraVal[tram_loader_pkg::A_DONE]    = done_q;
    csraVal[tram_loader_pkg::A_ERR]     = errAny;
    csrbVal = 16'h0000;
    csrbVal[tram_loader_pkg::B_MEMTO]   = memErr_q;
    csrbVal[tram_loader_pkg::B_DEMTO]   = demErr_q;
    csrbVal[tram_loader_pkg::B_TTYPE +: 3] = testType_q;
    rdMux = 16'h0000;
    if (selA) rdMux = csraVal;
    if (selB) rdMux = csrbVal;
    if (selBa) rdMux = busAddr_q;
    if (selBc) rdMux = {4'h0, byteCnt_q};
    if (selCk) rdMux = {8'h00, cksum_q};
    if (selRa) rdMux = {8'h00, ramAddr_q};
    if (selRd) rdMux = {3'h0, ramRdata};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= apbAcc & ~pready_q;
      pslverr_q <= apbAcc & ~pready_q & ~mapped;
      if (apbAcc && !pready_q) prdata_q <= {16'h0000, rdMux};
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign dmaReq        = dmaReq_q;
  assign msyn          = msyn_q;
  assign dmaAddr       = dmaAddr_q;
  assign intReq        = intReq_q;
  assign printerStrobe = lptStrobe_q;
  assign printerData   = lptData_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (clr);

  property p_aclo_quiet;
    acLo |=> !dmaReq_q && !intReq_q;
  endproperty
  a_aclo_quiet : assert property (p_aclo_quiet) else $error("request raised during power fail");
  property p_go_start;
    goSet && !errAny && !acLo ##1 !acLo[*2] |=> dmaReq_q && ramAddr_q == 8'h00;
  endproperty
  a_go_start : assert property (p_go_start) else $error("go did not start a request");
  property p_timeout;
    toErr |=> memErr_q && !msyn_q && state_q == tram_loader_pkg::ST_IDLE;
  endproperty
  a_timeout : assert property (p_timeout) else $error("timeout not handled");
  property p_no_req_err;
    errAny |=> !dmaReq_q;
  endproperty
  a_no_req_err : assert property (p_no_req_err) else $error("request while in error");
  property p_finish;
    finish |=> done_q && !go_q ##1 !dmaReq_q;
  endproperty
  a_finish : assert property (p_finish) else $error("counter overflow not handled");
  property p_ram_step;
    capture |=> ramAddr_q == $past(ramAddr_q) + 8'($past(busAddr_q[0])) && busAddr_q == $past(busAddr_q) + 16'h0001;
  endproperty
  a_ram_step : assert property (p_ram_step) else $error("address stepping wrong");
  property p_cksum;
    capture |=> cksum_q == $past(cksum_q) + charBuf_q;
  endproperty
  a_cksum : assert property (p_cksum) else $error("checksum sum wrong");
  property p_sim_quiet;
    isSim && $past(isSim) |-> !lptStrobe_q;
  endproperty
  a_sim_quiet : assert property (p_sim_quiet) else $error("printer strobed in load or test mode");
  property p_dma_addr;
    $rose(msyn_q) |-> dmaAddr_q == {$past(addrX_q), $past(busAddr_q)};
  endproperty
  a_dma_addr : assert property (p_dma_addr) else $error("dma address wrong");
  property p_demand_done;
    $rose(printerDemand) |=> ##1 done_q;
  endproperty
  a_demand_done : assert property (p_demand_done) else $error("demand did not set done");

  c_full_byte : cover property (capture && isRamLoad);
  c_finish    : cover property (finish);
  c_timeout   : cover property (toErr);
  c_resume    : cover property (errRst && go_q ##[1:20] dmaReq_q);
endmodule : translation_ram_dma_loader
`default_nettype wire

// [include/tram_loader_pkg.sv]
// Constants and types shared by the translation RAM DMA loader.
`default_nettype none
package tram_loader_pkg;
  // Register byte offsets on the register bus.
  localparam logic [11:0] OFF_CONTROL_STATUS_FIRST   = 12'h000;
  localparam logic [11:0] OFF_CONTROL_STATUS_SECOND   = 12'h004;
  localparam logic [11:0] OFF_BADDR  = 12'h008;
  localparam logic [11:0] OFF_BCNT   = 12'h00C;
  localparam logic [11:0] OFF_CKSUM  = 12'h010;
  localparam logic [11:0] OFF_RAMADR = 12'h014;
  localparam logic [11:0] OFF_RAMDAT = 12'h018;
  // Field positions in control_status_first.
  localparam int A_GO     = 0;
  localparam int A_TEST   = 2;
  localparam int A_FMT    = 3;
  localparam int A_ADRX   = 4;
  localparam int A_INTEN  = 6;
  localparam int A_DONE   = 7;
  localparam int A_ERRRST = 8;
  localparam int A_LINIT  = 9;
  localparam int A_ERR    = 15;
  // Field positions in control_status_second.
  localparam int B_MEMTO  = 0;
  localparam int B_DEMTO  = 1;
  localparam int B_TTYPE  = 4;
  localparam logic [2:0] TT_RAMPAR = 3'h1;
  // Operating modes as {format_unit_load, test_mode}.
  localparam logic [1:0] MODE_PRINT   = 2'h0;
  localparam logic [1:0] MODE_TEST    = 2'h1;
  localparam logic [1:0] MODE_FORMAT  = 2'h2;
  localparam logic [1:0] MODE_RAMLOAD = 2'h3;
  // Timing.
  localparam int CLK_NS        = 25;
  localparam int MEM_TO_NS     = 10000;
  localparam int DEMAND_TO_NS  = 100000;
  localparam logic [11:0] MEM_TO_CYC    = 12'((MEM_TO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] DEMAND_TO_CYC = 12'((DEMAND_TO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BCNT_LAST = 12'h000;
  localparam logic [7:0]  RAM_FIRST = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_REQ    = 4'h2,
    ST_XFER   = 4'h4,
    ST_STROBE = 4'h8
  } state_t;
endpackage : tram_loader_pkg
`default_nettype wire

// [tb/host_mem_model.sv]
// Host arbiter and main memory model that answers the loader's DMA reads.
`default_nettype none
module host_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        dmaReq,
  input  wire logic        msyn,
  input  wire logic [17:0] dmaAddr,
  output logic             dmaGrant,
  output logic             ssyn,
  output logic      [15:0] dmaRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  int          lat = 0;
  logic        mute = 1'h0;
  initial begin
    dmaGrant = 1'h0;
    ssyn = 1'h0;
    dmaRdata = 16'hFFFF;
  end
  // Idle data lines toggle every cycle so that a stale word is never mistaken for a reply.
  always begin
    @(posedge mclk);
    dmaRdata <= ~dmaRdata;
    if (!rst && dmaReq) begin
      repeat (lat) @(posedge mclk);
      dmaGrant <= 1'h1;
      do @(posedge mclk); while (!msyn && !rst);
      dmaGrant <= 1'h0;
      if (mute) begin
        while (msyn) @(posedge mclk);
      end else begin
        repeat (lat) @(posedge mclk);
        ssyn <= 1'h1;
        dmaRdata <= mem[dmaAddr[8:1]];
        @(posedge mclk);
        ssyn <= 1'h0;
        dmaRdata <= ~mem[dmaAddr[8:1]];
      end
    end
  end
endmodule : host_mem_model
`default_nettype wire

// [tb/translation_ram_dma_loader_tb.sv]
// Self-checking bench for the translation RAM DMA loader.
`default_nettype none
module translation_ram_dma_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, rst = 1'h1, busInit = 1'h0, acLo = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, printerDemand = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, dmaReq, dmaGrant, msyn, ssyn, intReq, printerStrobe, e;
  logic [17:0] dmaAddr, a;
  logic [15:0] dmaRdata;
  logic [7:0]  printerData, b, sum;
  logic [17:0] addrQ[$];
  logic [7:0]  byteQ[$];
  int          failures = 0, n_checks = 0, nStb = 0;

  always #12.5 mclk = ~mclk;

  translation_ram_dma_loader DUT (
    .mclk(mclk), .rst(rst), .busInit(busInit), .acLo(acLo), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmaReq(dmaReq), .dmaGrant(dmaGrant), .msyn(msyn), .dmaAddr(dmaAddr),
    .ssyn(ssyn), .dmaRdata(dmaRdata), .intReq(intReq), .printerDemand(printerDemand),
    .printerStrobe(printerStrobe), .printerData(printerData)
  );
  host_mem_model host (
    .mclk(mclk), .rst(rst), .dmaReq(dmaReq), .msyn(msyn), .dmaAddr(dmaAddr),
    .dmaGrant(dmaGrant), .ssyn(ssyn), .dmaRdata(dmaRdata)
  );

  task automatic check(input logic [31:0] s, input logic [31:0] x, input string m);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, m, s, x);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      failures++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'h1, ad, d);
  endtask : wr

  task automatic rd(input logic [11:0] ad);
    apb(1'h0, ad, 32'h0);
  endtask : rd

  task automatic waitBit(input int bt);
    for (int i = 0; i < 3000; i++) begin
      rd(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST);
      if (q[bt] === 1'h1) return;
    end
    failures++;
    summarize();
  endtask : waitBit

  // Reference model: expected addresses are queued at go, bytes and checksum follow each reply.
  always @(posedge mclk) begin
    if (!rst && msyn && ssyn) begin
      b = dmaAddr[0] ? dmaRdata[15:8] : dmaRdata[7:0];
      a = addrQ.size() > 0 ? addrQ.pop_front() : 18'h3FFFF;
      check(dmaAddr, a, "dma address");
      sum += b;
      byteQ.push_back(b);
    end
    if (!rst && printerStrobe) begin
      nStb++;
      check(printerData, byteQ.size() > 0 ? byteQ.pop_front() : 8'h00, "printer byte");
    end
    if (acLo && dmaReq) check(dmaReq, 1'h0, "request under power fail");
  end

  // Fault 1 lets memory stay silent once, fault 2 holds power fail across the start.
  task automatic run(input logic [1:0] md, input int n, input int lt, input logic ev, input int flt);
    logic [17:0] base;
    logic [31:0] c;
    logic [15:0] d;
    base = {2'($urandom), 6'($urandom), 1'h0, 8'($urandom), 1'h0};
    c = {24'h000000, 2'h1, base[17:16], md, 2'h0};
    host.lat = lt;
    host.mute = (flt == 1);
    wr(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST, 32'h00000200);
    rd(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST);
    check(q[15:0], 16'h0000, "after local init");
    sum = 8'h00;
    byteQ.delete();
    nStb = 0;
    wr(tram_loader_pkg::OFF_CONTROL_STATUS_SECOND, ev ? 32'(tram_loader_pkg::TT_RAMPAR) << tram_loader_pkg::B_TTYPE : 32'h0);
    wr(tram_loader_pkg::OFF_BADDR, 32'(base[15:0]));
    wr(tram_loader_pkg::OFF_BCNT, 32'(12'(-n)));
    wr(tram_loader_pkg::OFF_RAMADR, 32'h0000005A);
    wr(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST, c);
    for (int i = 0; i < n; i++) addrQ.push_back(base + 18'(i));
    if (flt == 2) acLo <= 1'h1;
    wr(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST, c | 32'h1);
    if (flt == 2) begin
      repeat (30) @(posedge mclk);
      acLo <= 1'h0;
    end
    if (flt == 1) begin
      waitBit(tram_loader_pkg::A_ERR);
      repeat (20) @(posedge mclk);
      check({msyn, dmaReq, intReq}, 3'h1, "halted after timeout");
      rd(tram_loader_pkg::OFF_CONTROL_STATUS_SECOND);
      check(q[1:0], 2'h1, "memory timeout flag");
      host.mute = 1'h0;
      wr(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST, c | 32'h101);
    end
    waitBit(tram_loader_pkg::A_DONE);
    check(q[15:0], 16'(c[7:0] | 8'h80), "done set, go clear");
    @(posedge mclk);
    check(intReq, 1'h1, "completion interrupt");
    rd(tram_loader_pkg::OFF_BADDR);
    check(q[15:0], base[15:0] + 16'(n), "bus address");
    rd(tram_loader_pkg::OFF_BCNT);
    check(q[11:0], 12'h000, "byte counter");
    rd(tram_loader_pkg::OFF_CKSUM);
    check(q[7:0], sum, "checksum");
    check(32'(addrQ.size()), 32'h0, "request count");
    check(32'(nStb), md[0] ? 32'h0 : 32'(n), "printer strobes");
    for (int k = 0; k < n / 2 && md == tram_loader_pkg::MODE_RAMLOAD; k++) begin
      d = host.mem[base[8:1] + 8'(k)];
      wr(tram_loader_pkg::OFF_RAMADR, 32'(k));
      rd(tram_loader_pkg::OFF_RAMDAT);
      check(q[12:0], {ev ^ ~^d[11:0], d[11:0]}, "RAM word");
    end
  endtask : run

  initial begin
    #2500000;
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(17));
    for (int i = 0; i < 256; i++) host.mem[i] = 16'($urandom);
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    rd(12'hFFC);
    check({e, q[15:0]}, 17'h10000, "unmapped access");
    rd(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST);
    check(q[7], 1'h0, "done before demand");
    printerDemand <= 1'h1;
    rd(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST);
    check(q[7], 1'h1, "done on demand");
    run(tram_loader_pkg::MODE_RAMLOAD, 512, 0, 1'h0, 0);
    run(tram_loader_pkg::MODE_RAMLOAD, 6, 3, 1'h1, 0);
    run(tram_loader_pkg::MODE_TEST, 4, 1, 1'h0, 0);
    run(tram_loader_pkg::MODE_PRINT, 4, 0, 1'h0, 0);
    run(tram_loader_pkg::MODE_FORMAT, 4, 2, 1'h0, 0);
    run(tram_loader_pkg::MODE_RAMLOAD, 4, 0, 1'h0, 1);
    run(tram_loader_pkg::MODE_RAMLOAD, 4, 1, 1'h0, 2);
    busInit <= 1'h1;
    @(posedge mclk);
    busInit <= 1'h0;
    rd(tram_loader_pkg::OFF_CONTROL_STATUS_FIRST);
    check(q[15:0], 16'h0000, "bus initialize");
    summarize();
  end
endmodule : translation_ram_dma_loader_tb
`default_nettype wire
